// ### src/rotiu_pkg.sv
// Overview of operation
// - rotate left to working: operand left, bit 7 into bit 0, carry kept
// - rotate left through carry in memory: old carry to bit 0, bit 7 to carry
// - rotate left through carry to working: result to working, carry from bit 7
// - rotate right in memory: bit 0 into bit 7, no flag changes
// - rotate right to working: bit 0 into bit 7, flags unchanged
// - rotate right through carry in memory: old carry to bit 7, bit 0 to carry
// - variants writing working register never write data memory back
package rotiu_pkg;
  localparam int ROTIU_DW = 8;
  localparam int ROTIU_MSB = 7;
  localparam int ROTIU_LSB = 0;
  localparam logic [7:0] ROTIU_WORK_RST = 8'h00;
  localparam logic ROTIU_CARRY_RST = 1'b0;
  localparam logic ROTIU_ZERO_RST = 1'b0;

  typedef enum logic [2:0] {
    ROTIU_OP_NONE = 3'b000,
    ROTIU_OP_LEFT_WORK = 3'b001,
    ROTIU_OP_LEFT_CARRY = 3'b010,
    ROTIU_OP_LEFT_CARRY_WORK = 3'b011,
    ROTIU_OP_RIGHT = 3'b100,
    ROTIU_OP_RIGHT_WORK = 3'b101,
    ROTIU_OP_RIGHT_CARRY = 3'b110,
    ROTIU_OP_LEFT_MEM = 3'b111
  } rotiu_op_t;
endpackage

// ### src/rotiu_shifter.sv
`timescale 1ns/10ps
module rotiu_shifter
  import rotiu_pkg::*;
#(
  parameter int DW = ROTIU_DW
) (
  input wire rotiu_op_t op,
  input wire logic [DW-1:0] operand,
  input wire logic carry_in,
  output logic [DW-1:0] result,
  output logic carry_out,
  output logic to_mem,
  output logic to_work,
  output logic carry_we
);
  always_comb begin
    result = operand;
    carry_out = carry_in;
    to_mem = 1'b0;
    to_work = 1'b0;
    carry_we = 1'b0;
    case (op)
      ROTIU_OP_LEFT_WORK: begin
        result = {operand[DW-2:0], operand[DW-1]};
        to_work = 1'b1;
      end
      ROTIU_OP_LEFT_CARRY: begin
        result = {operand[DW-2:0], carry_in};
        carry_out = operand[DW-1];
        to_mem = 1'b1;
        carry_we = 1'b1;
      end
      ROTIU_OP_LEFT_CARRY_WORK: begin
        result = {operand[DW-2:0], carry_in};
        carry_out = operand[DW-1];
        to_work = 1'b1;
        carry_we = 1'b1;
      end
      ROTIU_OP_RIGHT: begin
        result = {operand[ROTIU_LSB], operand[DW-1:1]};
        to_mem = 1'b1;
      end
      ROTIU_OP_RIGHT_WORK: begin
        result = {operand[ROTIU_LSB], operand[DW-1:1]};
        to_work = 1'b1;
      end
      ROTIU_OP_RIGHT_CARRY: begin
        result = {carry_in, operand[DW-1:1]};
        carry_out = operand[ROTIU_LSB];
        to_mem = 1'b1;
        carry_we = 1'b1;
      end
      ROTIU_OP_LEFT_MEM: begin
        result = {operand[DW-2:0], operand[DW-1]};
        to_mem = 1'b1;
      end
      default: begin
        result = operand;
      end
    endcase
  end
endmodule

// ### src/rotiu_top.sv
`timescale 1ns/10ps
module rotiu_top
  import rotiu_pkg::*;
#(
  parameter int DW = ROTIU_DW
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic [2:0] OP_CODE,
  input wire logic [DW-1:0] MEM_RDATA,
  output logic [DW-1:0] MEM_WDATA,
  output logic MEM_WE,
  output logic [DW-1:0] WORK,
  output logic CARRY,
  output logic ZERO,
  output logic DONE
);
  rotiu_op_t op;
  logic [DW-1:0] result;
  logic carry_out;
  logic to_mem;
  logic to_work;
  logic carry_we;
  logic [DW-1:0] wdata_reg;
  logic we_reg;
  logic [DW-1:0] work_reg;
  logic carry_reg;
  logic done_reg;
  logic zero_reg;

  // working-register forms, no memory write
  function automatic logic is_work_form(input rotiu_op_t code);
    case (code)
      ROTIU_OP_LEFT_WORK, ROTIU_OP_LEFT_CARRY_WORK, ROTIU_OP_RIGHT_WORK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // in-place forms, memory write requested
  function automatic logic is_mem_form(input rotiu_op_t code);
    case (code)
      ROTIU_OP_LEFT_CARRY, ROTIU_OP_RIGHT, ROTIU_OP_RIGHT_CARRY, ROTIU_OP_LEFT_MEM: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // through-carry forms, carry written
  function automatic logic is_carry_form(input rotiu_op_t code);
    case (code)
      ROTIU_OP_LEFT_CARRY, ROTIU_OP_LEFT_CARRY_WORK, ROTIU_OP_RIGHT_CARRY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // idle code when not valid
  assign op = OP_VALID ? rotiu_op_t'(OP_CODE) : ROTIU_OP_NONE;

  rotiu_shifter #(
    .DW(DW)
  ) u_shift (
    .op(op),
    .operand(MEM_RDATA),
    .carry_in(carry_reg),
    .result(result),
    .carry_out(carry_out),
    .to_mem(to_mem),
    .to_work(to_work),
    .carry_we(carry_we)
  );

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wdata_reg <= '0;
      we_reg <= 1'b0;
    end else begin
      we_reg <= to_mem;
      if (to_mem) begin
        wdata_reg <= result;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      work_reg <= ROTIU_WORK_RST;
    end else if (to_work) begin
      work_reg <= result;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      carry_reg <= ROTIU_CARRY_RST;
    end else if (carry_we) begin
      carry_reg <= carry_out;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= OP_VALID && (op != ROTIU_OP_NONE);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      zero_reg <= ROTIU_ZERO_RST;
    end else begin
      zero_reg <= zero_reg;
    end
  end

  assign MEM_WDATA = wdata_reg;
  assign MEM_WE = we_reg;
  assign WORK = work_reg;
  assign CARRY = carry_reg;
  assign ZERO = zero_reg;
  assign DONE = done_reg;

  property p_left_work;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_LEFT_WORK) |=> (WORK == {$past(MEM_RDATA[DW-2:0]), $past(MEM_RDATA[DW-1])})
        && $stable(CARRY) && !MEM_WE;
  endproperty
  a_left_work: assert property (p_left_work) else $error("left rotate to working wrong");

  property p_left_carry;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_LEFT_CARRY) |=> MEM_WE && (MEM_WDATA == {$past(MEM_RDATA[DW-2:0]), $past(CARRY)})
        && (CARRY == $past(MEM_RDATA[DW-1]));
  endproperty
  a_left_carry: assert property (p_left_carry) else $error("left rotate through carry wrong");

  property p_left_carry_work;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_LEFT_CARRY_WORK) |=> (WORK == {$past(MEM_RDATA[DW-2:0]), $past(CARRY)})
        && (CARRY == $past(MEM_RDATA[DW-1])) && !MEM_WE;
  endproperty
  a_left_carry_work: assert property (p_left_carry_work) else $error("carry rotate to working wrong");

  property p_right;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_RIGHT) |=> MEM_WE && $stable(CARRY)
        && (MEM_WDATA == {$past(MEM_RDATA[ROTIU_LSB]), $past(MEM_RDATA[DW-1:1])});
  endproperty
  a_right: assert property (p_right) else $error("right rotate wrong");

  property p_right_work;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_RIGHT_WORK) |=> (WORK == {$past(MEM_RDATA[ROTIU_LSB]), $past(MEM_RDATA[DW-1:1])})
        && $stable(CARRY) && !MEM_WE;
  endproperty
  a_right_work: assert property (p_right_work) else $error("right rotate to working wrong");

  property p_right_carry;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (op == ROTIU_OP_RIGHT_CARRY) |=> MEM_WE && (CARRY == $past(MEM_RDATA[ROTIU_LSB]))
        && (MEM_WDATA == {$past(CARRY), $past(MEM_RDATA[DW-1:1])});
  endproperty
  a_right_carry: assert property (p_right_carry) else $error("right rotate through carry wrong");

  property p_nowb;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      is_work_form(op) |=> !MEM_WE
        && $stable(MEM_WDATA);
  endproperty
  a_nowb: assert property (p_nowb) else $error("memory written by working form");

  property p_flags;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !is_carry_form(op) |=> $stable(CARRY)
        && !ZERO;
  endproperty
  a_flags: assert property (p_flags) else $error("flag changed");

  property p_mem_quiet;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !is_mem_form(op)
        |=> !MEM_WE;
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("memory write without in-place form");

  property p_work_kept;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !is_work_form(op)
        |=> $stable(WORK);
  endproperty
  a_work_kept: assert property (p_work_kept) else $error("working register changed");

  property p_decode;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (to_mem == is_mem_form(op)) && (to_work == is_work_form(op))
        && (carry_we == is_carry_form(op));
  endproperty
  a_decode: assert property (p_decode) else $error("shifter decode mismatch");

  // main scenarios
  c_left_carry: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (op == ROTIU_OP_LEFT_CARRY) ##1 CARRY);
  c_right_carry: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (op == ROTIU_OP_RIGHT_CARRY) ##1 MEM_WE);
  c_left_work: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (op == ROTIU_OP_LEFT_WORK) ##1 DONE);
  c_right_work: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (op == ROTIU_OP_RIGHT_WORK) ##1 DONE);
  c_carry_chain: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (op == ROTIU_OP_LEFT_CARRY) ##1 (op == ROTIU_OP_RIGHT_CARRY));
endmodule

// ### bench/rotiu_top_bench.sv
`timescale 1ns/10ps
module rotiu_top_bench;
  import rotiu_pkg::*;
  typedef struct {logic we; logic [7:0] wd; logic [7:0] work; logic c;} rotiu_note_t;
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  logic OP_VALID = 1'b0;
  logic [2:0] OP_CODE = 3'h0;
  logic [7:0] MEM_RDATA = 8'h00;
  logic [7:0] MEM_WDATA;
  logic MEM_WE;
  logic [7:0] WORK;
  logic CARRY;
  logic ZERO;
  logic DONE;
  int err_total = 0;
  int checks = 0;
  rotiu_note_t q[$];
  rotiu_note_t m;
  rotiu_note_t n;
  logic [31:0] r;

  always #10 CLK_SYS = ~CLK_SYS;

  rotiu_top dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .MEM_RDATA(MEM_RDATA), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .WORK(WORK), .CARRY(CARRY),
    .ZERO(ZERO), .DONE(DONE));

  task automatic cmp8(string name, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", name, e, g);
    end
  endtask

  task automatic cmp1(string name, logic e, logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %b got %b", name, e, g);
    end
  endtask

  task automatic issue(logic v, logic [2:0] code, logic [7:0] d);
    @(posedge CLK_SYS);
    #1;
    OP_VALID = v;
    OP_CODE = code;
    MEM_RDATA = d;
    if (v && code != 3'h0) begin
      m.we = 1'b0;
      case (code)
        3'h1: m.work = {d[6:0], d[7]};
        3'h2: begin m.we = 1'b1; m.wd = {d[6:0], m.c}; m.c = d[7]; end
        3'h3: begin m.work = {d[6:0], m.c}; m.c = d[7]; end
        3'h4: begin m.we = 1'b1; m.wd = {d[0], d[7:1]}; end
        3'h5: m.work = {d[0], d[7:1]};
        3'h6: begin m.we = 1'b1; m.wd = {m.c, d[7:1]}; m.c = d[0]; end
        default: begin m.we = 1'b1; m.wd = {d[6:0], d[7]}; end
      endcase
      q.push_back(m);
    end
  endtask

  task automatic do_reset;
    @(posedge CLK_SYS);
    #1;
    RESET_N = 1'b0;
    OP_VALID = 1'b0;
    q.delete();
    m = '{1'b0, 8'h00, 8'h00, 1'b0};
    repeat (5) @(posedge CLK_SYS);
    cmp8("WORK", 8'h00, WORK);
    cmp1("CARRY", 1'b0, CARRY);
    #1;
    RESET_N = 1'b1;
  endtask

  task end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // result check on each done pulse
  always @(negedge CLK_SYS) begin
    if (RESET_N === 1'b1 && DONE === 1'b1) begin
      cmp1("DONE", q.size() != 0, 1'b1);
      if (q.size() != 0) begin
        n = q.pop_front();
        cmp1("MEM_WE", n.we, MEM_WE);
        cmp8("MEM_WDATA", n.wd, MEM_WDATA);
        cmp8("WORK", n.work, WORK);
        cmp1("CARRY", n.c, CARRY);
        cmp1("ZERO", 1'b0, ZERO);
      end
    end else if (RESET_N === 1'b1) begin
      cmp1("MEM_WE", 1'b0, MEM_WE);
    end
  end

  initial begin
    #100000;
    err_total++;
    end_of_test;
  end

  initial begin
    void'($urandom(36498));
    do_reset;
    for (int k = 0; k < 16; k++) issue(1'b1, k[2:0], k[3] ? 8'h81 : 8'h7e);
    $display("test directed done");
    for (int k = 0; k < 200; k++) begin
      r = $urandom;
      issue(r[8], r[2:0], r[16:9]);
    end
    $display("test random done");
    issue(1'b1, 3'h6, 8'h01);
    issue(1'b0, 3'h0, 8'h00);
    do_reset;
    issue(1'b1, 3'h2, 8'hff);
    issue(1'b0, 3'h0, 8'h00);
    repeat (2) @(posedge CLK_SYS);
    cmp8("queue", 8'h00, 8'(q.size()));
    $display("test reset done");
    end_of_test;
  end
endmodule
